// *** logic/sld_lcd_map.svh ***
// register map, bit fields, drive levels and divider figures of the lcd driver
// assumes a cpu byte bus with 16-bit addresses and a one-clock register write
`ifndef SLD_LCD_MAP_SVH
`define SLD_LCD_MAP_SVH

`define SLD_ADDR_MODE     16'hFFB0
`define SLD_ADDR_CLK      16'hFFB2
`define SLD_ADDR_MEM_LO   16'hFA00
`define SLD_ADDR_MEM_HI   16'hFA17
`define SLD_MEM_DEPTH     24
`define SLD_MODE_RESET    8'h00
`define SLD_MODE_WMASK    8'hD1
`define SLD_CLK_RESET     4'h0
`define SLD_BIT_ON        7
`define SLD_BIT_BOOST     6
`define SLD_BIT_PINS      4
`define SLD_BIT_SLICE     0
`define SLD_SRC_SUB       2'h0
`define SLD_SRC_EXP_BASE  4'h4
`define SLD_LCD_EXP_BASE  4'h6
`define SLD_LVL_GND       2'h0
`define SLD_LVL_THIRD     2'h1
`define SLD_LVL_TWO_THIRD 2'h2
`define SLD_LVL_FULL      2'h3

`endif

// *** logic/sld_pkg.sv ***
// types shared by the lcd driver
// assumes sld_lcd_map.svh supplies the numeric constants
package sld_pkg;
  // one-hot common slot, bit n selects common n
  typedef enum logic [3:0] {
    SLD_SLOT0 = 4'b0001,
    SLD_SLOT1 = 4'b0010,
    SLD_SLOT2 = 4'b0100,
    SLD_SLOT3 = 4'b1000
  } sld_slot_t;
  typedef logic [1:0] sld_lvl_t;
endpackage

// *** logic/sld_lcd_driver.sv ***
// segment lcd driver: mode and clock registers, display memory, scan timing
// assumes a synchronous cpu byte port and an external 1/3 bias level switch
// that turns each 2-bit level code into a pin voltage
`timescale 1ns/1ps
`include "sld_lcd_map.svh"

module sld_lcd_driver
  import sld_pkg::*;
(
  input  wire logic        clk_sys,     // 25 mhz system clock
  input  wire logic        rst_n,       // async system reset
  input  wire logic        ce,          // clock enable, low freezes all
  input  wire logic [15:0] addr,        // cpu byte address
  input  wire logic [7:0]  wdata,       // cpu write data
  input  wire logic        wr_en,       // cpu write strobe
  input  wire logic        rd_en,       // cpu read strobe
  input  wire logic        sub_clk,     // subsystem clock, sampled level
  output logic      [7:0]  rdata_q,     // cpu read data, one cycle late
  output logic      [47:0] seg_level_q, // 24 segment level codes
  output logic      [7:0]  com_level_q, // 4 common level codes
  output logic             booster_run_q // booster run request
);

  // registers and memory
  logic [7:0]  display_mode_reg_q;
  logic [3:0]  lcd_clock_ctrl_reg_q;
  logic [3:0]  mem_q [`SLD_MEM_DEPTH];
  logic [6:0]  pre_q;
  logic [8:0]  div_q;
  logic        sub_q;
  logic        pol_q;
  sld_slot_t   slot_q;
  sld_slot_t   slot_d;
  logic        pol_d;
  logic [47:0] seg_d;
  logic [7:0]  com_d;

  // true when the low n bits of v are all ones
  function automatic logic low_ones(input logic [8:0] v, input logic [3:0] n);
    logic [8:0] m;
    m = 9'((10'h001 << n) - 10'h001);
    return (v & m) == m;
  endfunction

  // index of the active common
  function automatic logic [1:0] slot_idx(input sld_slot_t s);
    return {s[3] | s[2], s[3] | s[1]};
  endfunction

  // address decode
  wire        hit_mode  = addr == `SLD_ADDR_MODE;
  wire        hit_clk   = addr == `SLD_ADDR_CLK;
  wire        hit_mem   = addr >= `SLD_ADDR_MEM_LO && addr <= `SLD_ADDR_MEM_HI;
  wire [15:0] mem_off   = addr - `SLD_ADDR_MEM_LO;
  wire [4:0]  mem_idx   = mem_off[4:0];
  wire        disp_on   = display_mode_reg_q[`SLD_BIT_ON];
  wire        pins_on   = display_mode_reg_q[`SLD_BIT_PINS];
  wire        three     = display_mode_reg_q[`SLD_BIT_SLICE];
  wire [7:0]  rd_mux    = hit_mode ? display_mode_reg_q :
                          hit_clk  ? {4'h0, lcd_clock_ctrl_reg_q} :
                          hit_mem  ? {4'h0, mem_q[mem_idx]} : 8'h00;

  // frame-rate dividers; subsystem path lets timing run from the slow clock
  // both counters run free, so the first frame after a rate change is short;
  // software is expected to change the rate only while the display is off
  wire [1:0]  src_sel   = lcd_clock_ctrl_reg_q[3:2];
  wire        sub_tick  = sub_clk & ~sub_q;
  wire        main_tick = low_ones({2'h0, pre_q}, `SLD_SRC_EXP_BASE + {2'h0, src_sel});
  wire        src_tick  = (src_sel == `SLD_SRC_SUB) ? sub_tick : main_tick;
  wire        lcd_tick  = src_tick &&
                          low_ones(div_q, `SLD_LCD_EXP_BASE + {2'h0, lcd_clock_ctrl_reg_q[1:0]});
  wire        slot_last = three ? slot_q == SLD_SLOT2 : slot_q == SLD_SLOT3;

  // polarity-dependent level codes, swapped every frame to cancel dc
  wire [1:0] com_sel = pol_q ? `SLD_LVL_GND       : `SLD_LVL_FULL;
  wire [1:0] com_uns = pol_q ? `SLD_LVL_TWO_THIRD : `SLD_LVL_THIRD;
  wire [1:0] seg_sel = pol_q ? `SLD_LVL_FULL      : `SLD_LVL_GND;
  wire [1:0] seg_des = pol_q ? `SLD_LVL_THIRD     : `SLD_LVL_TWO_THIRD;
  wire [1:0] cur_idx = slot_idx(slot_q);

  // slot sequencer; a stray slot 3 in three-slice mode is dropped at once
  // the dropped slot still shows on the commons for a cycle or two after a
  // mode switch, which is why the slice bit belongs in the power-up setup
  always_comb begin
    slot_d = slot_q;
    pol_d  = pol_q;
    if (three && slot_q == SLD_SLOT3) begin
      slot_d = SLD_SLOT0;
    end else if (lcd_tick) begin
      if (slot_last) begin
        slot_d = SLD_SLOT0;
        pol_d  = ~pol_q;
      end else begin
        unique case (slot_q)
          SLD_SLOT0: slot_d = SLD_SLOT1;
          SLD_SLOT1: slot_d = SLD_SLOT2;
          SLD_SLOT2: slot_d = SLD_SLOT3;
          default:   slot_d = SLD_SLOT0;
        endcase
      end
    end
  end

  // pin levels; memory is read by the scan itself and also by the cpu through rd_mux
  always_comb begin
    for (int i = 0; i < `SLD_MEM_DEPTH; i++) begin
      if (!pins_on)
        seg_d[2*i +: 2] = `SLD_LVL_GND;
      else if (!disp_on)
        seg_d[2*i +: 2] = seg_des;
      else
        seg_d[2*i +: 2] = mem_q[i][cur_idx] ? seg_sel : seg_des;
    end
    for (int c = 0; c < 4; c++) begin
      if (!pins_on)
        com_d[2*c +: 2] = `SLD_LVL_GND;
      else
        com_d[2*c +: 2] = slot_q[c] ? com_sel : com_uns;
    end
  end

  // cpu register writes; reserved mode bits are not stored
  // reads use the pre-edge value, so a write and read together return the old byte
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      display_mode_reg_q   <= `SLD_MODE_RESET;
      lcd_clock_ctrl_reg_q <= `SLD_CLK_RESET;
      rdata_q              <= 8'h00;
    end else if (ce) begin
      if (wr_en && hit_mode)
        display_mode_reg_q <= wdata & `SLD_MODE_WMASK;
      if (wr_en && hit_clk)
        lcd_clock_ctrl_reg_q <= wdata[3:0];
      if (rd_en)
        rdata_q <= rd_mux;
    end
  end

  // display memory keeps only the low nibble of each byte
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `SLD_MEM_DEPTH; i++)
        mem_q[i] <= 4'h0;
    end else if (ce && wr_en && hit_mem) begin
      mem_q[mem_idx] <= wdata[3:0];
    end
  end

  // timing state and output flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pre_q         <= 7'h00;
      div_q         <= 9'h000;
      sub_q         <= 1'b0;
      slot_q        <= SLD_SLOT0;
      pol_q         <= 1'b0;
      seg_level_q   <= 48'h0;
      com_level_q   <= 8'h00;
      booster_run_q <= 1'b0;
    end else if (ce) begin
      pre_q         <= pre_q + 7'h01;
      div_q         <= src_tick ? div_q + 9'h001 : div_q;
      sub_q         <= sub_clk;
      slot_q        <= slot_d;
      pol_q         <= pol_d;
      seg_level_q   <= seg_d;
      com_level_q   <= com_d;
      booster_run_q <= display_mode_reg_q[`SLD_BIT_BOOST];
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_pins_ground: assert property (ce && !pins_on |=> seg_level_q == 48'h0 && com_level_q == 8'h00)
    else $error("pins off but levels not ground");
  a_display_off_desel: assert property (ce && pins_on && !disp_on |=>
      seg_level_q == {24{$past(seg_des)}})
    else $error("display off but segments not deselect");
  a_seg0_follows: assert property (ce && pins_on && disp_on |=>
      seg_level_q[1:0] == ($past(mem_q[0][cur_idx]) ? $past(seg_sel) : $past(seg_des)))
    else $error("segment 0 does not follow memory bit");
  a_reset_mode_zero: assert property (@(posedge clk_sys) disable iff (1'b0)
      $rose(rst_n) |-> display_mode_reg_q == 8'h00)
    else $error("mode register not cleared by reset");
  a_three_no_common_out_3: assert property (ce && three && slot_q == SLD_SLOT3 |=> slot_q == SLD_SLOT0)
    else $error("slot 3 survived in three-slice mode");
  a_slot_step: assert property (ce && !three && lcd_tick && slot_q == SLD_SLOT1 |=>
      slot_q == SLD_SLOT2 ##0 $stable(pol_q))
    else $error("slot did not advance in order");
  a_pol_flip: assert property (ce && lcd_tick && slot_last |=> pol_q != $past(pol_q) && slot_q == SLD_SLOT0)
    else $error("polarity did not alternate at frame end");
  a_mem_upper_zero: assert property (ce && rd_en && hit_mem |=> rdata_q[7:4] == 4'h0)
    else $error("display memory upper bits not zero");
  a_booster_follow: assert property (ce |=> booster_run_q == $past(display_mode_reg_q[`SLD_BIT_BOOST]))
    else $error("booster output does not follow mode bit");

  // slot and polarity move only at their own events
  a_three_wrap: assert property (ce && three && lcd_tick && slot_q == SLD_SLOT2 |=>
      slot_q == SLD_SLOT0)
    else $error("three-slice scan went past common 2");
  a_slot_hold: assert property (ce && !lcd_tick && !(three && slot_q == SLD_SLOT3) |=>
      $stable(slot_q))
    else $error("slot moved without an lcd tick");
  a_pol_hold: assert property (ce && !(lcd_tick && slot_last) |=> $stable(pol_q))
    else $error("polarity changed inside a frame");
  // pins on always put a waveform on the commons; the last segment tracks the last byte
  a_pins_com_wave: assert property (ce && pins_on |=> com_level_q != 8'h00)
    else $error("pins on but commons at ground");
  a_seg_last_follows: assert property (ce && pins_on && disp_on |=>
      seg_level_q[2*`SLD_MEM_DEPTH-1 -: 2] ==
      ($past(mem_q[`SLD_MEM_DEPTH-1][cur_idx]) ? $past(seg_sel) : $past(seg_des)))
    else $error("last segment does not follow last memory byte");

  // covers for the main scan scenarios
  c_three_frame: cover property (ce && three && lcd_tick && slot_q == SLD_SLOT2);
  c_four_frame: cover property (ce && !three && lcd_tick && slot_q == SLD_SLOT3);
  c_display_on: cover property (ce && pins_on && disp_on && seg_level_q != 48'h0);
  c_sub_clock: cover property (ce && src_sel == `SLD_SRC_SUB && lcd_tick);
  c_three_drop: cover property (ce && three && slot_q == SLD_SLOT3);

endmodule

// *** test/sld_panel_model.sv ***
// panel model: level codes in, selected common and lit pixels out
// assumes codes 0..3 mean ground, one third, two thirds, full drive
`timescale 1ns/1ps
module sld_panel_model (
  input  wire logic [47:0] seg_level, // segment level codes
  input  wire logic [7:0]  com_level, // common level codes
  output logic      [2:0]  sel_com,   // selected common, 4 when none
  output logic             sel_pol,   // high when the select pulse sits at ground
  output logic      [23:0] lit        // pixel on the selected common is lit
);
  logic [1:0] sl;
  // with all commons grounded the pins are off, so nothing counts as selected
  always_comb begin
    sel_com = 3'h4;
    sl = 2'h0;
    for (int c = 0; c < 4; c++) begin
      if (com_level != 8'h00 && (com_level[2*c +: 2] == 2'h3 || com_level[2*c +: 2] == 2'h0)) begin
        sel_com = 3'(c);
        sl = com_level[2*c +: 2];
      end
    end
    sel_pol = (sl == 2'h0);
    // only the full voltage lights a pixel
    for (int i = 0; i < 24; i++) begin
      lit[i] = (sel_com != 3'h4) && ((sl ^ seg_level[2*i +: 2]) == 2'h3) && (sl[0] == sl[1]);
    end
  end
endmodule

// *** test/testbench.sv ***
// bench for the lcd driver: register port, scan order, drive levels, frame rates
// assumes the panel model and the driver's map header compile alongside
`timescale 1ns/1ps
`include "sld_lcd_map.svh"
module testbench;
  logic        clk_sys = 0, rst_n = 0, ce = 1, wr_en = 0, rd_en = 0, sub_clk = 0, disp_on = 0;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00, rdata_q, com_level_q;
  logic [47:0] seg_level_q;
  logic        booster_run_q, sel_pol;
  logic [2:0]  sel_com;
  logic [23:0] lit;
  logic [3:0]  mem [24];
  int          err_total = 0, n_checks = 0, cyc = 0, n;
  localparam int BOOST_WAIT = 16;   // booster settle wait, plain stand-in figure
  localparam int CHG_LIMIT  = 9000; // longest wait for a common change, above the slowest slot t_rates selects
  sld_lcd_driver uut (.clk_sys, .rst_n, .ce, .addr, .wdata, .wr_en, .rd_en, .sub_clk,
    .rdata_q, .seg_level_q, .com_level_q, .booster_run_q);
  sld_panel_model panel (.seg_level(seg_level_q), .com_level(com_level_q), .sel_com,
    .sel_pol, .lit);
  // system clock, and a subsystem clock rising every second cycle
  always #20 clk_sys = ~clk_sys;
  always @(negedge clk_sys) sub_clk <= ~sub_clk;
  // hang guard, well above the longest expected run
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [55:0] got, input logic [55:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // cpu strobes are raised at a falling edge and dropped at the next one;
  // an idle cycle follows so back-to-back calls never retoggle a strobe
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr_en = 1;
    @(negedge clk_sys);
    wr_en = 0;
    @(negedge clk_sys);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    addr = a;
    rd_en = 1;
    @(negedge clk_sys);
    rd_en = 0;
    check(rdata_q, exp);
    @(negedge clk_sys);
  endtask
  task automatic wait_change(output int k);
    logic [7:0] old;
    old = com_level_q;
    k = 0;
    while (com_level_q === old && k < CHG_LIMIT) begin
      @(negedge clk_sys);
      k++;
    end
  endtask
  // follow the scan slot by slot and judge commons, segments and pixels
  task automatic scan(input int nsl, input int nslots);
    logic [2:0]  prev;
    logic        ppol;
    logic [47:0] exp;
    logic [23:0] xl;
    prev = 3'h7;
    ppol = 0;
    repeat (nslots) begin
      wait_change(n);
      check(n < CHG_LIMIT, 1);
      if (prev != 3'h7) check(sel_com, (prev + 1) % nsl);
      if (prev != 3'h7 && sel_com == 3'h0) check(sel_pol, !ppol);
      check(sel_com < nsl, 1);
      for (int i = 0; i < 24; i++) begin
        xl[i] = disp_on && mem[i][sel_com[1:0]];
        exp[2*i +: 2] = xl[i] ? {2{sel_pol}} : {~sel_pol, sel_pol};
      end
      check(seg_level_q, exp);
      check(lit, xl);
      prev = sel_com;
      ppol = sel_pol;
    end
  endtask
  task automatic t_regs();
    rd(`SLD_ADDR_MODE, 8'h00);
    for (int i = 0; i < 24; i++) begin
      mem[i] = 4'(i * 5 + 3);
      wr(`SLD_ADDR_MEM_LO + 16'(i), {4'hF, mem[i]});
    end
    rd(`SLD_ADDR_MEM_LO, {4'h0, mem[0]});
    rd(`SLD_ADDR_MEM_HI, {4'h0, mem[23]});
    rd(16'hFA18, 8'h00);
    wr(`SLD_ADDR_MODE, 8'h2E);
    rd(`SLD_ADDR_MODE, 8'h00);
    wr(`SLD_ADDR_CLK, 8'hF1);
    rd(`SLD_ADDR_CLK, 8'h01);
    ce = 0;
    wr(`SLD_ADDR_MODE, 8'h40);
    ce = 1;
    rd(`SLD_ADDR_MODE, 8'h00);
  endtask
  task automatic t_power_up();
    wr(`SLD_ADDR_CLK, 8'h00);
    wr(`SLD_ADDR_MODE, 8'h40);
    @(negedge clk_sys);
    check(booster_run_q, 1);
    check({seg_level_q, com_level_q}, 0);
    repeat (BOOST_WAIT) @(negedge clk_sys);
    wr(`SLD_ADDR_MODE, 8'h50);
    scan(4, 2);
    wr(`SLD_ADDR_MODE, 8'hD0);
    disp_on = 1;
    scan(4, 10);
  endtask
  task automatic t_three();
    // switch while common 3 is selected, so the stray slot must be dropped
    repeat (4) if (sel_com != 3'h3) wait_change(n);
    check(sel_com, 3'h3);
    wr(`SLD_ADDR_MODE, 8'hD1);
    scan(3, 8);
    wr(`SLD_ADDR_MODE, 8'hD0);
  endtask
  task automatic t_shutdown();
    wr(`SLD_ADDR_MODE, 8'h50);
    disp_on = 0;
    scan(4, 2);
    wr(`SLD_ADDR_MODE, 8'h40);
    @(negedge clk_sys);
    check({seg_level_q, com_level_q}, 0);
    wr(`SLD_ADDR_MODE, 8'h00);
    @(negedge clk_sys);
    check(booster_run_q, 0);
  endtask
  // the first interval after a divider change is partial, so time the second;
  // every source is visited, and every divider setting with the subsystem source
  task automatic t_rates();
    logic [7:0] ctl;
    int         per;
    wr(`SLD_ADDR_MODE, 8'h40);
    repeat (BOOST_WAIT) @(negedge clk_sys);
    wr(`SLD_ADDR_MODE, 8'h50);
    for (int k = 0; k < 7; k++) begin
      ctl = (k < 4) ? 8'(k) : 8'(4 * (k - 3));
      per = ((k < 4) ? 2 : (16 << (k - 3))) << (6 + ctl[1:0]);
      wr(`SLD_ADDR_CLK, ctl);
      wait_change(n);
      wait_change(n);
      check(n, per);
    end
    wr(`SLD_ADDR_MODE, 8'h40);
    wr(`SLD_ADDR_MODE, 8'h00);
    check(booster_run_q, 0);
    check({seg_level_q, com_level_q}, 0);
  endtask
  initial begin
    repeat (2) @(negedge clk_sys);
    rst_n = 1;
    t_regs();
    t_power_up();
    t_three();
    t_shutdown();
    t_rates();
    give_verdict();
  end
endmodule
